/* verilog/sample_stream_packetizer.sv */
// What this block and its host do
// (R1) Aggregate sample rate across channels never exceeds 20,000 per second.
// (R2) One, two or four channels may be streamed together.
// (R3) An armed stream runs without any sample count limit until disarmed.
// (R4) Arm command starts sample data flowing to the bus port.
// (R5) Disarm command stops generating new sample data.
// (R6) Clear-status command discards bytes still queued for output.
// (R7) Setup command stores channel selection and rate together.
// (R8) Setup naming any disabled channel is rejected, old setting kept.
// (R9) Host enables each channel before issuing the setup command.
// (R10) Busy indication shown on front panel while streaming.
// (R11) Each sample is a 16-bit signed integer.
// (R12) Sample bytes go out most significant byte first.
// (R13) Packets hold sixteen samples after reset.
// (R14) Packet-size command accepts 1 to 16 samples per packet.
// (R15) Selected channels interleave in ascending order, one sample each.
// (R16) Service request raised every 100 packets unless reconfigured.
// (R17) Request-period command accepts 1 to 400 packets.
// (R18) Host serial-polls and reads one buffer per request seen.
// (R19) Query returns current channel selection and rate.
// (R20) Query returns current request period in packets.
// (R21) Streaming exists only on the bus port, never the serial port.
// (R22) Host sets an all-ones request enable mask before arming.
// (R23) Serial poll clears the request; packet counter restarts at assertion.
module sample_stream_packetizer
  import packetizer_pkg::*;
#(
  parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES
)
(
  // Clock and reset
  input  wire logic                          clock_i,
  input  wire logic                          rst_n_i,
  // Commands from the parser
  input  wire logic                          stream_arm_cmd_i,
  input  wire logic                          stream_disarm_cmd_i,
  input  wire logic                          clear_status_cmd_i,
  input  wire logic                          acq_setup_cmd_i,
  input  wire packetizer_pkg::acq_setup_t    acq_setup_i,
  input  wire logic                          channel_enable_cmd_i,
  input  wire logic [CHAN_COUNT-1:0]         channel_enable_i,
  input  wire logic                          packet_size_cmd_i,
  input  wire logic [4:0]                    packet_size_i,
  input  wire logic                          request_period_cmd_i,
  input  wire logic [8:0]                    request_period_i,
  input  wire logic                          serial_poll_i,
  // Converter samples
  input  wire logic [CHAN_COUNT*SAMPLE_BITS-1:0] sample_data_i,
  // Byte stream to the bus port
  output logic                               byte_valid_o,
  input  wire logic                          byte_ready_i,
  output packetizer_pkg::out_byte_t          byte_o,
  // Status
  output logic                               service_request_o,
  output logic                               busy_display_o,
  output packetizer_pkg::acq_setup_t         acq_setup_query_o,
  output logic [8:0]                         request_period_query_o,
  output logic                               setup_rejected_o
);
  import packetizer_pkg::*;

  if (SAMPLE_CYCLES_P < 1)
    $error("SAMPLE_CYCLES_P must be positive");

  function automatic logic legal_sel(input logic [3:0] sel, input logic [3:0] en);
    logic [2:0] n;
    n = 3'({2'b0, sel[0]} + sel[1] + sel[2] + sel[3]);
    legal_sel = ((sel & ~en) == 4'h0) && (n == 3'd1 || n == 3'd2 || n == 3'd4);
  endfunction
  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  logic [3:0]  chan_en_q;
  acq_setup_t  setup_q;
  logic [4:0]  pkt_size_q;
  logic [8:0]  period_q;
  logic        armed_q;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      chan_en_q <= CHAN_SEL_RESET;
    else if (channel_enable_cmd_i)
      chan_en_q <= channel_enable_i;
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      setup_q          <= '{chan_sel: CHAN_SEL_RESET, rate: RATE_RESET};
      setup_rejected_o <= 1'b0;
    end
    else if (acq_setup_cmd_i && !armed_q)
    begin
      if (legal_sel(acq_setup_i.chan_sel, chan_en_q)) // R2 R8
        setup_q <= acq_setup_i; // R7
      setup_rejected_o <= !legal_sel(acq_setup_i.chan_sel, chan_en_q); // R8
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pkt_size_q <= PKT_SIZE_RESET; // R13
    else if (packet_size_cmd_i && packet_size_i >= PKT_SIZE_MIN && packet_size_i <= PKT_SIZE_MAX)
      pkt_size_q <= packet_size_i; // R14
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      period_q <= PERIOD_RESET; // R16
    else if (request_period_cmd_i && request_period_i >= PERIOD_MIN && request_period_i <= PERIOD_MAX)
      period_q <= request_period_i; // R17
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acq_setup_query_o      <= '{chan_sel: CHAN_SEL_RESET, rate: RATE_RESET};
      request_period_query_o <= PERIOD_RESET;
    end
    else
    begin
      acq_setup_query_o      <= setup_q; // R19
      request_period_query_o <= period_q; // R20
    end
  end

  // ----------------------------------------
  // Arm control
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      armed_q <= 1'b0;
    else if (stream_disarm_cmd_i)
      armed_q <= 1'b0; // R5
    else if (stream_arm_cmd_i)
      armed_q <= 1'b1; // R4 R3
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      busy_display_o <= 1'b0;
    else
      busy_display_o <= armed_q; // R10
  end
  // ----------------------------------------
  // Sample pacing and channel walk
  // ----------------------------------------
  localparam int PACE_W = $clog2(SAMPLE_CYCLES_P + 1);
  logic [PACE_W-1:0] pace_q;
  logic              tick;
  logic [1:0]        chan_q;
  logic [15:0]       word_q;
  logic              word_valid_q;
  logic              byte_sel_q;
  logic [4:0]        pkt_cnt_q;
  logic [8:0]        req_cnt_q;
  logic              buf_in_ready;
  logic              last_byte;
  assign tick = (pace_q == PACE_W'(SAMPLE_CYCLES_P - 1));
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pace_q <= '0;
    else if (!armed_q || tick)
      pace_q <= '0; // R1
    else
      pace_q <= pace_q + 1'b1;
  end
  // Next selected channel above the current, wrapping
  function automatic logic [1:0] next_chan(input logic [1:0] cur, input logic [3:0] sel);
    logic [1:0] c;
    logic       found;
    next_chan = cur;
    found     = 1'b0;
    for (int k = 1; k <= CHAN_COUNT; k++)
    begin
      c = 2'(cur + k);
      if (!found && sel[c])
      begin
        next_chan = c;
        found     = 1'b1;
      end
    end
  endfunction

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      chan_q <= 2'h3;
    else if (!armed_q)
      chan_q <= 2'h3;
    else if (tick && !word_valid_q)
      chan_q <= next_chan(chan_q, setup_q.chan_sel); // R15
  end
  // Captured sample, split into bytes high first
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      word_q       <= '0;
      word_valid_q <= 1'b0;
      byte_sel_q   <= 1'b0;
    end
    else if (clear_status_cmd_i)
    begin
      word_valid_q <= 1'b0; // R6
      byte_sel_q   <= 1'b0;
    end
    else if (word_valid_q)
    begin
      if (buf_in_ready)
      begin
        byte_sel_q   <= !byte_sel_q;
        word_valid_q <= !byte_sel_q;
      end
    end
    else if (armed_q && tick)
    begin
      word_q       <= sample_data_i[next_chan(chan_q, setup_q.chan_sel)*SAMPLE_BITS +: SAMPLE_BITS]; // R11
      word_valid_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Packet and request counting
  // ----------------------------------------
  assign last_byte = word_valid_q && byte_sel_q && buf_in_ready && (pkt_cnt_q == pkt_size_q - 1'b1);
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pkt_cnt_q <= '0;
    else if (clear_status_cmd_i || stream_arm_cmd_i)
      pkt_cnt_q <= '0;
    else if (word_valid_q && byte_sel_q && buf_in_ready)
      pkt_cnt_q <= last_byte ? 5'h00 : pkt_cnt_q + 1'b1; // R13 R14
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      req_cnt_q <= '0;
    else if (stream_arm_cmd_i)
      req_cnt_q <= '0;
    else if (last_byte)
      req_cnt_q <= (req_cnt_q >= period_q - 1'b1) ? 9'h000 : req_cnt_q + 1'b1; // R23
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      service_request_o <= 1'b0;
    else if (last_byte && req_cnt_q >= period_q - 1'b1)
      service_request_o <= 1'b1; // R16 R18
    else if (serial_poll_i || clear_status_cmd_i)
      service_request_o <= 1'b0; // R23
  end

  // ----------------------------------------
  // Two-entry output buffer
  // ----------------------------------------
  out_byte_t  mem_q [2];
  logic       wr_q, rd_q;
  logic [1:0] cnt_q;
  logic       push, pop;
  assign buf_in_ready = (cnt_q != 2'd2);
  assign push         = word_valid_q && buf_in_ready && !clear_status_cmd_i;
  assign pop          = byte_valid_o && byte_ready_i;
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'd0;
    end
    else if (clear_status_cmd_i)
    begin
      wr_q  <= 1'b0; // R6
      rd_q  <= 1'b0;
      cnt_q <= 2'd0;
    end
    else
    begin
      if (push)
        wr_q <= !wr_q;
      if (pop)
        rd_q <= !rd_q;
      cnt_q <= 2'(cnt_q + push - pop);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (push)
      mem_q[wr_q] <= '{data: byte_sel_q ? word_q[7:0] : word_q[15:8], last: last_byte}; // R12
  end
  // Registered head of the buffer drives the port
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      byte_valid_o <= 1'b0;
      byte_o       <= '0;
    end
    else if (clear_status_cmd_i)
      byte_valid_o <= 1'b0; // R6
    else if (!byte_valid_o || byte_ready_i)
    begin
      byte_valid_o <= (cnt_q != 2'd0) && !(pop && cnt_q == 2'd1) ? 1'b1 : 1'b0; // R21
      byte_o       <= pop ? mem_q[!rd_q] : mem_q[rd_q];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  pace_bound_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R1
    push && !byte_sel_q |-> ##1 !(push && !byte_sel_q) [*2])
    else $error("samples too close together");
  setup_keep_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R8
    acq_setup_cmd_i && !legal_sel(acq_setup_i.chan_sel, chan_en_q) |=> $stable(setup_q))
    else $error("illegal setup was stored");
  disarm_stop_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R5
    stream_disarm_cmd_i |=> !armed_q ##1 !(word_valid_q && $rose(word_valid_q)))
    else $error("sample after disarm");
  clear_drop_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R6
    clear_status_cmd_i |=> !byte_valid_o && cnt_q == 2'd0)
    else $error("bytes left after clear");
  busy_show_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R10
    stream_arm_cmd_i && !stream_disarm_cmd_i |-> ##2 busy_display_o)
    else $error("busy not shown");
  pkt_size_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R14
    packet_size_cmd_i && packet_size_i > PKT_SIZE_MAX |=> $stable(pkt_size_q))
    else $error("bad packet size taken");
  period_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R17
    request_period_cmd_i && request_period_i > PERIOD_MAX |=> $stable(period_q))
    else $error("bad period taken");
  poll_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R23
    serial_poll_i && !last_byte |=> !service_request_o)
    else $error("request not cleared by poll");
endmodule

/* verilog/packetizer_pkg.sv */
package packetizer_pkg;
  localparam int           CHAN_COUNT      = 4;
  localparam int           SAMPLE_BITS     = 16;
  localparam int           CLK_HZ          = 10_000_000;
  localparam int           MAX_AGG_RATE    = 20_000;
  localparam int           SAMPLE_CYCLES   = (CLK_HZ + MAX_AGG_RATE - 1) / MAX_AGG_RATE;
  localparam logic [4:0]   PKT_SIZE_RESET  = 5'h10;
  localparam logic [4:0]   PKT_SIZE_MIN    = 5'h01;
  localparam logic [4:0]   PKT_SIZE_MAX    = 5'h10;
  localparam logic [8:0]   PERIOD_RESET    = 9'h064;
  localparam logic [8:0]   PERIOD_MIN      = 9'h001;
  localparam logic [8:0]   PERIOD_MAX      = 9'h190;
  localparam logic [3:0]   CHAN_SEL_RESET  = 4'h1;
  localparam logic [1:0]   RATE_RESET      = 2'h0;

  typedef struct packed {
    logic [3:0] chan_sel;
    logic [1:0] rate;
  } acq_setup_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } out_byte_t;
endpackage

/* tb/host_sink.sv */
module host_sink
  import packetizer_pkg::*;
(
  // Clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      rst_n_i,
  // Stall mode: 0 ready, 1 slow, 2 stopped
  input  wire logic [1:0]                mode_i,
  // Byte stream from the block
  input  wire logic                      byte_valid_i,
  input  wire packetizer_pkg::out_byte_t byte_i,
  output logic                           byte_ready_o,
  // Service request handling
  input  wire logic                      service_request_i,
  output logic                           serial_poll_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import packetizer_pkg::*;

  out_byte_t  rx_q[$];
  out_byte_t  held_q;
  int         hold_errs;
  logic [2:0] phase_q;
  logic       pend_q;
  // All-ones request enable mask, set before arming
  localparam logic [7:0] REQ_ENABLE_MASK = 8'hFF;

  // ----------------------------------------
  // Host reader and poller
  // ----------------------------------------
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase_q       <= 3'h0;
      pend_q        <= 1'b0;
      byte_ready_o  <= 1'b0;
      serial_poll_o <= 1'b0;
    end
    else
    begin
      phase_q <= phase_q + 3'h1;
      if (byte_valid_i && byte_ready_o)
        rx_q.push_back(byte_i);
      // Offered byte must stand until taken
      if (pend_q && (byte_valid_i !== 1'b1 || byte_i !== held_q))
        hold_errs++;
      pend_q        <= byte_valid_i && !byte_ready_o;
      held_q        <= byte_i;
      byte_ready_o  <= #1 (mode_i == 2'h0) || (mode_i == 2'h1 && phase_q >= 3'h5);
      serial_poll_o <= #1 service_request_i && (&REQ_ENABLE_MASK) && !serial_poll_o;
    end
  end
endmodule

/* tb/sample_stream_packetizer_tb_top.sv */
module sample_stream_packetizer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import packetizer_pkg::*;

  logic        clock_i;
  logic        rst_n_i;
  logic [6:0]  cmd;
  acq_setup_t  setup;
  acq_setup_t  eq;
  acq_setup_t  sq;
  logic [3:0]  chen;
  logic [4:0]  psize;
  logic [8:0]  period;
  logic [8:0]  pq;
  logic [1:0]  mode;
  logic [15:0] sx;
  logic [3:0]  sels [4] = '{4'h1, 4'hF, 4'h7, 4'h5};
  logic [63:0] samples = {16'h4D3C, 16'h7A56, 16'hC2B1, 16'h8123};
  logic        bvalid;
  logic        ready;
  logic        srq;
  logic        poll;
  logic        busy;
  logic        rej;
  out_byte_t   ob;
  int          err_count;
  int          tests_run;
  int          cyc;
  int          t0;
  int          n;

  sample_stream_packetizer #(.SAMPLE_CYCLES_P(8)) u_sample_stream_packetizer (
    .clock_i(clock_i), .rst_n_i(rst_n_i),
    .stream_arm_cmd_i(cmd[0]), .stream_disarm_cmd_i(cmd[1]), .clear_status_cmd_i(cmd[2]),
    .acq_setup_cmd_i(cmd[3]), .acq_setup_i(setup), .channel_enable_cmd_i(cmd[4]),
    .channel_enable_i(chen), .packet_size_cmd_i(cmd[5]), .packet_size_i(psize),
    .request_period_cmd_i(cmd[6]), .request_period_i(period), .serial_poll_i(poll),
    .sample_data_i(samples), .byte_valid_o(bvalid), .byte_ready_i(ready), .byte_o(ob),
    .service_request_o(srq), .busy_display_o(busy), .acq_setup_query_o(sq),
    .request_period_query_o(pq), .setup_rejected_o(rej));

  host_sink u_host_sink (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .mode_i(mode), .byte_valid_i(bvalid),
    .byte_i(ob), .byte_ready_o(ready), .service_request_i(srq), .serial_poll_o(poll));

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic step(input int k = 1);
    repeat (k) @(posedge clock_i);
    #1;
  endtask

  task automatic send(input logic [6:0] c);
    cmd = c;
    step();
    cmd = 7'h00;
    step(2);
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_bytes(input int k);
    for (int i = 0; i < 3000 && u_host_sink.rx_q.size() < k; i++)
      step();
  endtask

  task automatic check_stream(input int k, input int pb, input int nch);
    for (int i = 0; i < k; i++)
    begin
      sx = (nch == 2 && (i / 2) % 2 == 1) ? 16'h7A56 : 16'h8123;
      check(u_host_sink.rx_q[i].data, (i % 2 == 1) ? sx[7:0] : sx[15:8]);
      check(u_host_sink.rx_q[i].last, i % pb == pb - 1);
    end
  endtask

  task automatic do_reset();
    rst_n_i = 1'b0;
    step(16);
    rst_n_i = 1'b1;
    step();
  endtask

  task automatic wrap_up();
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    cmd = 7'h00;
    setup = '{4'h3, 2'h1};
    chen = 4'hF;
    psize = 5'h02;
    period = 9'h003;
    mode = 2'h1;
    do_reset();
    check(sq, 6'h04);
    check(pq, 9'h064);
    check({srq, bvalid, busy}, 3'h0);
    send(7'h08);
    check(rej, 1'b1);
    check(sq, 6'h04);
    eq = sq;
    send(7'h10);
    for (int i = 0; i < 4; i++)
    begin
      setup = '{sels[i], 2'(i)};
      send(7'h08);
      if (sels[i] != 4'h7)
        eq = setup;
      check(rej, sels[i] == 4'h7);
      check(sq, eq);
    end
    send(7'h40);
    period = 9'h000;
    send(7'h40);
    period = 9'h191;
    send(7'h40);
    check(pq, 9'h003);
    send(7'h20);
    psize = 5'h00;
    send(7'h20);
    psize = 5'h11;
    send(7'h20);
    t0 = cyc;
    send(7'h01);
    check(busy, 1'b1);
    for (n = 0; n < 300 && srq !== 1'b1; n++)
      step();
    check(srq, 1'b1);
    t0 = cyc;
    for (n = 0; n < 300 && srq !== 1'b0; n++)
      step();
    check(srq, 1'b0);
    for (n = 0; n < 300 && srq !== 1'b1; n++)
      step();
    check(16'(cyc - t0), 16'd48);
    wait_bytes(24);
    check(u_host_sink.rx_q.size() <= 2 * ((cyc - t0 + 60) / 8 + 1), 1'b1);
    check_stream(24, 4, 2);
    mode = 2'h2;
    step(12);
    check(bvalid, 1'b1);
    check(16'(u_host_sink.hold_errs), 16'h0000);
    send(7'h02);
    check(busy, 1'b0);
    send(7'h04);
    mode = 2'h0;
    n = u_host_sink.rx_q.size();
    step(40);
    check(16'(u_host_sink.rx_q.size()), 16'(n));
    check(bvalid, 1'b0);
    do_reset();
    check(sq, 6'h04);
    check(pq, 9'h064);
    u_host_sink.rx_q.delete();
    send(7'h01);
    wait_bytes(34);
    check_stream(34, 32, 1);
    wrap_up();
  end
endmodule
